// >>> hw/ibe_pkg.sv
// package: register map, field positions, reset values and timing
// assumes a 50 MHz instruction-cycle clock and 32-bit apb data
`default_nettype none
package ibe_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFS_TIMING = 8'h00;
    localparam logic [7:0] OFS_UNLOCK = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // write-pulse timing: bit 7 fixed zero, 10 MHz range code on reset
    localparam logic [6:0] TIMING_RST = 7'h7B;
    localparam int TIMING_W = 7;
    // unlock pattern in bits 7..2
    localparam logic [5:0] UNLOCK_KEY = 6'h26;
    localparam int KEY_LSB = 2;
    localparam int KEY_MSB = 7;
    localparam logic [3:0] UNLOCK_CYCLES = 4'h8;
    // high voltage held this many cycles beyond reset
    localparam logic [1:0] HV_HOLD_CYCLES = 2'h3;
    // control fields
    localparam int CTL_WRITE = 0;
    localparam int CTL_PAGE_ERASE = 1;
    localparam int CTL_MASS_ERASE = 2;
    localparam int CTL_OPT_PAGE = 3;
    localparam int CTL_USER_ISP = 4;
    // status fields
    localparam int ST_UNLOCK = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_BOOT = 2;
    localparam int ST_FORCED = 3;
    localparam int ST_BOOT_SEL = 4;
    localparam int ST_SECURITY = 5;
    localparam int ST_FORCE_PIN = 6;
    localparam int ST_START_OK = 7;
    localparam int ST_W = 8;
    // erased option bits read as zero
    localparam logic OPT_ERASED = 1'b0;
    typedef enum logic [1:0]
    {
        IBE_OP_WRITE = 2'b00,
        IBE_OP_PAGE = 2'b01,
        IBE_OP_MASS = 2'b10
    } ibe_op_e;
endpackage
`default_nettype wire

// >>> hw/ibe_pulse_if.sv
// carrier between the control core and the pulse-width timer
// assumes both ends share the instruction-cycle clock
`default_nettype none
interface ibe_pulse_if;
    import ibe_pkg::*;
    logic [TIMING_W-1:0] code;
    logic start;
    ibe_op_e op;
    logic busy;
    logic done;
    ibe_op_e done_op;
    logic pulse;
    modport ctrl (output code, output start, output op,
        input busy, input done, input done_op, input pulse);
    modport timer (input code, input start, input op,
        output busy, output done, output done_op, output pulse);
endinterface
`default_nettype wire

// >>> hw/ibe_pulse_timer.sv
// write/erase pulse timer: width scales with the timing code
// assumes the caller holds code steady while busy
`default_nettype none
module ibe_pulse_timer
    import ibe_pkg::*;
#(
    parameter int UNIT_CYCLES = 8,
    parameter int CNT_W = 12
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    ibe_pulse_if.timer pif
);
    typedef enum logic [2:0]
    {
        PT_IDLE = 3'b001,
        PT_PULSE = 3'b010,
        PT_DONE = 3'b100
    } ibe_pt_e;

    ibe_pt_e state;
    ibe_pt_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] width;
    wire cnt_zero = (cnt == '0);

    // code times unit gives the count; the pulse lasts one cycle longer
    assign width = CNT_W'(pif.code * UNIT_CYCLES);

    always_comb
    begin
        next_state = state;
        case (state)
            PT_IDLE: if (pif.start) next_state = PT_PULSE;
            PT_PULSE: if (cnt_zero) next_state = PT_DONE;
            PT_DONE: next_state = PT_IDLE;
            default: next_state = PT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= PT_IDLE;
            cnt <= '0;
            pif.pulse <= 1'b0;
            pif.busy <= 1'b0;
            pif.done <= 1'b0;
            pif.done_op <= IBE_OP_WRITE;
        end
        else if (i_ce)
        begin
            state <= next_state;
            cnt <= (state == PT_IDLE) ? width : cnt - 1'b1;
            pif.pulse <= (next_state == PT_PULSE);
            pif.busy <= (next_state != PT_IDLE);
            pif.done <= (next_state == PT_DONE);
            if (state == PT_IDLE && pif.start)
                pif.done_op <= pif.op;
        end
    end
endmodule
`default_nettype wire

// >>> hw/ibe_top.sv
// in-system programming support: pulse timing, boot unlock, forced boot
// assumes apb master on the core clock; one clock cycle per instruction
// cycle; hv qualifier and pins already at digital levels
//
// Operation
// - write/erase pulse width is set by the timing register value.
// - timing code is picked by software from the input clock frequency range.
// - reset loads the timing code for the 10 MHz range.
// - timing bit 7 reads fixed and read-only; bits 6..0 read/write.
// - jump-to-boot reaches boot ROM only while unlocked, else stays in flash.
// - unlock sets only on pattern 100110 in bits 7..2; mismatch clears.
// - unlock flag lasts exactly 8 instruction cycles then clears.
// - emulation breakpoint freezes the unlock counter while active.
// - unlock countdown keeps running through interrupt service.
// - return-to-flash from boot ROM resumes flash execution.
// - hv qualifier at reset release forces boot ROM at 0000.
// - later normal reset follows boot-select bit, flash unless erased.
// - forced boot never changes boot-select or security bits.
// - security clears only by mass erase, or under user ISP control.
// - while hv is present the load clock drives the shift clock pin.
// - force pin reads as 1 while hv is present.
// - normal reset: boot-select 0 starts boot ROM, 1 starts flash.
`default_nettype none
module ibe_top
    import ibe_pkg::*;
#(
    parameter int PULSE_UNIT_CYCLES = 8,
    parameter int LOAD_CLK_HALF = 4
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ibe_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [ibe_pkg::DATA_W-1:0] i_pwdata,
    input wire logic i_jump_to_boot_instr,
    input wire logic i_return_to_flash_instr,
    input wire logic i_emu_mode,
    input wire logic i_breakpoint,
    input wire logic i_hv_force_pin,
    input wire logic i_force_pin_level,
    input wire logic i_opt_boot_select,
    input wire logic i_opt_security,
    output logic [ibe_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_exec_boot,
    output logic o_boot_jump,
    output logic o_flash_jump,
    output logic o_start_valid,
    output logic o_forced_boot,
    output logic o_unlocked,
    output logic o_flash_pulse,
    output logic o_flash_busy,
    output logic o_opt_boot_select,
    output logic o_opt_security,
    output logic o_force_pin_read,
    output logic o_load_clock_pin,
    output logic o_load_clock_oe
);
    ibe_pulse_if pif ();

    // apb decode; one wait state so every answer comes from a flop
    wire setup_acc = i_psel & i_penable & ~o_pready;
    wire done_acc = i_psel & i_penable & o_pready;
    wire wr = done_acc & i_pwrite;
    wire sel_timing = (i_paddr == OFS_TIMING);
    wire sel_unlock = (i_paddr == OFS_UNLOCK);
    wire sel_control = (i_paddr == OFS_CONTROL);
    wire sel_status = (i_paddr == OFS_STATUS);
    wire mapped = sel_timing | sel_unlock | sel_control | sel_status;

    logic [TIMING_W-1:0] timing;
    logic user_isp;
    logic unlock;
    logic [3:0] unlock_cnt;
    logic hv_meta;
    logic hv_sync;
    logic [1:0] start_cnt;
    logic started;
    logic [$clog2(LOAD_CLK_HALF+1)-1:0] lclk_cnt;
    logic [DATA_W-1:0] rd_mux;
    logic [ST_W-1:0] status;

    // key compare ignores the two low bits
    wire key_write = wr & sel_unlock;
    wire key_match = (i_pwdata[KEY_MSB:KEY_LSB] == UNLOCK_KEY);
    // breakpoint in emulation holds the count; interrupts do not
    wire unlock_hold = i_emu_mode & i_breakpoint;
    wire unlock_last = (unlock_cnt == 4'h0) & ~unlock_hold;

    // option-page erase clears boot-select; security only under user isp
    wire erase_done = pif.done;
    wire mass_done = erase_done & (pif.done_op == IBE_OP_MASS);
    wire page_done = erase_done & (pif.done_op == IBE_OP_PAGE);
    logic opt_page_op;

    // start a flash operation from a control write
    wire ctl_write = wr & sel_control & ~pif.busy;
    wire go_write = ctl_write & i_pwdata[CTL_WRITE];
    wire go_page = ctl_write & i_pwdata[CTL_PAGE_ERASE];
    wire go_mass = ctl_write & i_pwdata[CTL_MASS_ERASE];

    assign pif.code = timing;
    assign pif.start = go_write | go_page | go_mass;
    assign pif.op = go_mass ? IBE_OP_MASS : (go_page ? IBE_OP_PAGE : IBE_OP_WRITE);

    assign status[ST_UNLOCK] = unlock;
    assign status[ST_BUSY] = pif.busy;
    assign status[ST_BOOT] = o_exec_boot;
    assign status[ST_FORCED] = o_forced_boot;
    assign status[ST_BOOT_SEL] = o_opt_boot_select;
    assign status[ST_SECURITY] = o_opt_security;
    assign status[ST_FORCE_PIN] = o_force_pin_read;
    assign status[ST_START_OK] = o_start_valid;

    // bit 7 of timing always reads zero
    assign rd_mux = sel_timing ? DATA_W'({1'b0, timing}) :
        sel_control ? DATA_W'({user_isp, opt_page_op, 3'b000}) :
        sel_status ? DATA_W'(status) : '0;

    ibe_pulse_timer #(
        .UNIT_CYCLES(PULSE_UNIT_CYCLES),
        .CNT_W(12)
    ) u_timer (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_ce(i_ce),
        .pif(pif.timer)
    );

    // apb answer path
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end
        else if (i_ce)
        begin
            o_pready <= setup_acc;
            o_pslverr <= setup_acc & ~mapped;
            o_prdata <= (setup_acc & ~i_pwrite) ? rd_mux : '0;
        end
    end

    // software-written state
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            timing <= TIMING_RST;
            user_isp <= 1'b0;
            opt_page_op <= 1'b0;
        end
        else if (i_ce)
        begin
            if (wr & sel_timing)
                timing <= i_pwdata[TIMING_W-1:0];
            if (wr & sel_control)
                user_isp <= i_pwdata[CTL_USER_ISP];
            if (go_page)
                opt_page_op <= i_pwdata[CTL_OPT_PAGE];
        end
    end

    // unlock window
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            unlock <= 1'b0;
            unlock_cnt <= '0;
        end
        else if (i_ce)
        begin
            if (key_write)
            begin
                unlock <= key_match;
                unlock_cnt <= UNLOCK_CYCLES - 4'h1;
            end
            else if (unlock)
            begin
                if (!unlock_hold)
                    unlock_cnt <= unlock_cnt - 4'h1;
                if (unlock_last)
                    unlock <= 1'b0;
            end
        end
    end

    // hv qualifier synchroniser; second flop is the only reader of first
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            hv_meta <= 1'b0;
            hv_sync <= 1'b0;
        end
        else if (i_ce)
        begin
            hv_meta <= i_hv_force_pin;
            hv_sync <= hv_meta;
        end
    end

    // reset exit: wait out the synchroniser inside the hv hold window
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            start_cnt <= '0;
            started <= 1'b0;
            o_start_valid <= 1'b0;
            o_forced_boot <= 1'b0;
            o_opt_boot_select <= OPT_ERASED;
            o_opt_security <= OPT_ERASED;
        end
        else if (i_ce)
        begin
            if (!started)
            begin
                start_cnt <= start_cnt + 2'h1;
                if (start_cnt == HV_HOLD_CYCLES - 2'h1)
                begin
                    started <= 1'b1;
                    o_start_valid <= 1'b1;
                    o_forced_boot <= hv_sync;
                    // option bits taken as stored; forced entry leaves them
                    o_opt_boot_select <= i_opt_boot_select;
                    o_opt_security <= i_opt_security;
                end
            end
            else
            begin
                if (mass_done)
                begin
                    o_opt_boot_select <= OPT_ERASED;
                    o_opt_security <= OPT_ERASED;
                end
                else if (page_done & opt_page_op)
                begin
                    o_opt_boot_select <= OPT_ERASED;
                    if (user_isp)
                        o_opt_security <= OPT_ERASED;
                end
            end
        end
    end

    // execution region: reset choice, then jump and return
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            o_exec_boot <= 1'b0;
            o_boot_jump <= 1'b0;
            o_flash_jump <= 1'b0;
            o_unlocked <= 1'b0;
        end
        else if (i_ce)
        begin
            o_boot_jump <= 1'b0;
            o_flash_jump <= 1'b0;
            o_unlocked <= unlock;
            if (!started)
            begin
                if (start_cnt == HV_HOLD_CYCLES - 2'h1)
                    // hv overrides boot-select; else erased bit means boot rom
                    o_exec_boot <= hv_sync | ~i_opt_boot_select;
            end
            else if (i_jump_to_boot_instr)
            begin
                if (unlock)
                begin
                    o_exec_boot <= 1'b1;
                    o_boot_jump <= 1'b1;
                end
                else
                    o_flash_jump <= 1'b1;
            end
            else if (i_return_to_flash_instr & o_exec_boot)
            begin
                o_exec_boot <= 1'b0;
                o_flash_jump <= 1'b1;
            end
        end
    end

    // load clock onto shift clock pin while hv is present
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            lclk_cnt <= '0;
            o_load_clock_pin <= 1'b0;
            o_load_clock_oe <= 1'b0;
            o_force_pin_read <= 1'b0;
        end
        else if (i_ce)
        begin
            o_load_clock_oe <= hv_sync;
            o_force_pin_read <= hv_sync | i_force_pin_level;
            if (!hv_sync)
            begin
                lclk_cnt <= '0;
                o_load_clock_pin <= 1'b0;
            end
            else if (lclk_cnt == ($bits(lclk_cnt))'(LOAD_CLK_HALF - 1))
            begin
                lclk_cnt <= '0;
                o_load_clock_pin <= ~o_load_clock_pin;
            end
            else
                lclk_cnt <= lclk_cnt + 1'b1;
        end
    end

    // flash pulse and busy re-timed to keep outputs on flops
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            o_flash_pulse <= 1'b0;
            o_flash_busy <= 1'b0;
        end
        else if (i_ce)
        begin
            o_flash_pulse <= pif.pulse;
            o_flash_busy <= pif.busy;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/ibe_properties.sv
// checker: port-level timing relations of the isp boot and pulse block
// assumes one core clock domain; bound onto ibe_top below
`default_nettype none
module ibe_props
    import ibe_pkg::*;
#(
    parameter int PULSE_UNIT_CYCLES = 8
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ibe_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [ibe_pkg::DATA_W-1:0] i_pwdata,
    input wire logic i_jump_to_boot_instr,
    input wire logic i_return_to_flash_instr,
    input wire logic i_emu_mode,
    input wire logic i_hv_force_pin,
    input wire logic o_pready,
    input wire logic o_exec_boot,
    input wire logic o_boot_jump,
    input wire logic o_flash_jump,
    input wire logic o_start_valid,
    input wire logic o_forced_boot,
    input wire logic o_unlocked,
    input wire logic o_flash_pulse,
    input wire logic o_opt_boot_select,
    input wire logic o_load_clock_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_NRST);
    logic wr;
    logic key_wr;
    logic [6:0] tim;
    int wid;
    assign wr = i_psel && i_penable && i_pwrite && o_pready;
    assign key_wr = wr && i_paddr == OFS_UNLOCK;
    // shadow code: width is judged against what software last loaded
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            tim <= TIMING_RST;
            wid <= 0;
        end
        else
        begin
            if (wr && i_paddr == OFS_TIMING)
            begin
                tim <= i_pwdata[6:0];
            end
            wid <= o_flash_pulse ? wid + 1 : 0;
        end
    end
    property p_start;
        $rose(I_NRST) |-> !o_start_valid [*3] ##1 o_start_valid;
    endproperty
    a_start: assert property (p_start)
        else $error("start decision mistimed");
    property p_forced;
        $rose(o_start_valid) && o_forced_boot |-> o_exec_boot;
    endproperty
    a_forced: assert property (p_forced)
        else $error("forced start not in boot rom");
    property p_normal;
        $rose(o_start_valid) && !o_forced_boot |-> o_exec_boot == !o_opt_boot_select;
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal start ignores boot select");
    property p_key;
        key_wr && i_pwdata[7:2] == UNLOCK_KEY && !i_emu_mode
            |-> ##2 o_unlocked [*8] ##1 !o_unlocked;
    endproperty
    a_key: assert property (p_key)
        else $error("unlock window length wrong");
    property p_badkey;
        key_wr && i_pwdata[7:2] != UNLOCK_KEY |-> ##2 !o_unlocked;
    endproperty
    a_badkey: assert property (p_badkey)
        else $error("wrong key unlocked");
    property p_jump;
        i_jump_to_boot_instr |=> o_boot_jump == o_unlocked && o_flash_jump != o_unlocked;
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump target wrong");
    property p_ret;
        i_return_to_flash_instr && !i_jump_to_boot_instr && o_exec_boot
            |=> !o_exec_boot && o_flash_jump;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return did not reach flash");
    property p_width;
        $fell(o_flash_pulse) |-> wid == int'(tim) * PULSE_UNIT_CYCLES + 1;
    endproperty
    a_width: assert property (p_width)
        else $error("pulse width wrong");
    property p_hv;
        i_hv_force_pin [*5] |-> o_load_clock_oe;
    endproperty
    a_hv: assert property (p_hv)
        else $error("load clock not driven");
endmodule
bind ibe_top ibe_props #(.PULSE_UNIT_CYCLES(PULSE_UNIT_CYCLES)) u_props
(
    .I_CORE_CLK(I_CORE_CLK),
    .I_NRST(I_NRST),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_jump_to_boot_instr(i_jump_to_boot_instr),
    .i_return_to_flash_instr(i_return_to_flash_instr),
    .i_emu_mode(i_emu_mode),
    .i_hv_force_pin(i_hv_force_pin),
    .o_pready(o_pready),
    .o_exec_boot(o_exec_boot),
    .o_boot_jump(o_boot_jump),
    .o_flash_jump(o_flash_jump),
    .o_start_valid(o_start_valid),
    .o_forced_boot(o_forced_boot),
    .o_unlocked(o_unlocked),
    .o_flash_pulse(o_flash_pulse),
    .o_opt_boot_select(o_opt_boot_select),
    .o_load_clock_oe(o_load_clock_oe)
);
`default_nettype wire

// >>> testbench/ibe_programmer.sv
// partner: external programmer owning reset and the high-voltage pin
// assumes its tasks are called right after a rising clock edge
`default_nettype none
module ibe_programmer
(
    input wire logic i_clk,
    output logic o_nrst,
    output logic o_hv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_nrst = 1'b0;
        o_hv = 1'b0;
    end
    task automatic enter(input logic h);
        o_nrst <= 1'b0;
        @(posedge i_clk);
        o_hv <= h;
        repeat (9) @(posedge i_clk);
        o_nrst <= 1'b1;
    endtask
    // never drops high voltage sooner than three cycles after release
    task automatic leave(input int n);
        repeat ((n < 3) ? 3 : n) @(posedge i_clk);
        o_hv <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_isp_boot_entry_and_pulse_timing.sv
// testbench: apb, instruction pulses and option bits around ibe_top
// assumes ibe_programmer owns reset and the high-voltage pin
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_isp_boot_entry_and_pulse_timing;
    timeunit 1ns;
    timeprecision 1ns;
    import ibe_pkg::*;
    localparam int PU = 1;
    logic clk, nrst, hv, psel, pen, pwr, jmp, ret, emu, bp, lvl, sel, sec, ce, bsy;
    logic rdy, serr, xb, bj, fj, fb, unl, fp, osel, osec, frd, lck, loe, err;
    logic [7:0] pa;
    logic [31:0] pwd, prd, q;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int w;
    ibe_programmer prog (.i_clk(clk), .o_nrst(nrst), .o_hv(hv));
    ibe_top #(.PULSE_UNIT_CYCLES(PU), .LOAD_CLK_HALF(2)) dut
    (
        .I_CORE_CLK(clk),
        .I_NRST(nrst),
        .i_ce(ce),
        .i_psel(psel),
        .i_penable(pen),
        .i_pwrite(pwr),
        .i_paddr(pa),
        .i_pwdata(pwd),
        .i_jump_to_boot_instr(jmp),
        .i_return_to_flash_instr(ret),
        .i_emu_mode(emu),
        .i_breakpoint(bp),
        .i_hv_force_pin(hv),
        .i_force_pin_level(lvl),
        .i_opt_boot_select(sel),
        .i_opt_security(sec),
        .o_prdata(prd),
        .o_pready(rdy),
        .o_pslverr(serr),
        .o_exec_boot(xb),
        .o_boot_jump(bj),
        .o_flash_jump(fj),
        .o_start_valid(),
        .o_forced_boot(fb),
        .o_unlocked(unl),
        .o_flash_pulse(fp),
        .o_flash_busy(bsy),
        .o_opt_boot_select(osel),
        .o_opt_security(osec),
        .o_force_pin_read(frd),
        .o_load_clock_pin(lck),
        .o_load_clock_oe(loe)
    );
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic int pulse_len(input logic [31:0] c);
        return int'(c[6:0]) * PU + 1;
    endfunction
    task automatic print_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= wr;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rdy !== 1'b1 && n < 20);
        if (n == 20) n_errors++;
        q = prd;
        err = serr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic r);
        if (r) ret <= 1'b1;
        else jmp <= 1'b1;
        @(posedge clk);
        jmp <= 1'b0;
        ret <= 1'b0;
        #1;
    endtask
    task automatic boot(input logic h, input logic s, input logic c);
        sel <= s;
        sec <= c;
        prog.enter(h);
        repeat (5) @(posedge clk);
        #1;
    endtask
    // timing is left alone from the start write until the pulse is over
    task automatic op(input logic [31:0] c);
        apb(1'b1, OFS_CONTROL, c);
        w = 0;
        for (int n = 0; n < 400 && !(w > 0 && fp !== 1'b1); n++)
        begin
            @(posedge clk);
            w += int'(fp === 1'b1);
        end
        `CHK("busy_tail", 1, bsy)
        repeat (3) @(posedge clk);
        `CHK("busy_end", 0, bsy)
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        logic [31:0] d;
        logic c;
        logic p;
        {psel, pen, pwr, jmp, ret, emu, bp, lvl, sel, sec} = '0;
        pa = '0;
        pwd = '0;
        ce = 1'b1;
        void'($urandom(32'h3724));
        boot(1'b0, 1'b1, 1'b1);
        `CHK("exec_boot", 0, xb)
        @(posedge clk);
        apb(1'b0, OFS_TIMING, 32'h0000_0000);
        `CHK("timing_rst", {25'h0, TIMING_RST}, q)
        for (int i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            apb(1'b1, OFS_TIMING, d);
            lvl <= 1'($urandom);
            apb(1'b0, OFS_TIMING, 32'h0000_0000);
            `CHK("timing", {25'h0, d[6:0]}, q)
        end
        apb(1'b1, 8'h10, 32'h0000_0055);
        `CHK("slverr", 1, err)
        apb(1'b0, OFS_UNLOCK, 32'h0000_0000);
        `CHK("unlock_rd", 0, q)
        for (int k = 0; k < 3; k++)
        begin
            d = {24'h00_0000, UNLOCK_KEY ^ ((k == 0) ? 6'(1 + $urandom % 63) : 6'h00),
                2'($urandom)};
            // no interrupt source on this bench, so the window is never cut short
            apb(1'b1, OFS_UNLOCK, d);
            repeat ((k == 2) ? 7 : 6) @(posedge clk);
            pulse(1'b0);
            `CHK("boot_jump", k == 1, bj)
            `CHK("flash_jump", k != 1, fj)
            @(posedge clk);
            pulse(1'b1);
            `CHK("exec_boot", 0, xb)
            @(posedge clk);
        end
        emu <= 1'b1;
        // pass 0 freezes the count by breakpoint, pass 1 by clock enable
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY, 2'b00});
            w = 0;
            for (int i = 0; i < 20; i++)
            begin
                bp <= (i < 4) && (j == 0);
                ce <= !((i < 4) && (j == 1));
                @(posedge clk);
                w += int'(unl === 1'b1);
            end
            `CHK("unlock_len", 12, w)
        end
        emu <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 32'h0000_007B : 32'(1 + $urandom % 40);
            apb(1'b1, OFS_TIMING, d);
            op(32'h0000_0001);
            `CHK("pulse_w", pulse_len(d), w)
        end
        `CHK("opt_write", 2'b11, {osel, osec})
        op(32'h0000_000A);
        `CHK("opt_page", 2'b01, {osel, osec})
        op(32'h0000_001A);
        `CHK("opt_user", 2'b00, {osel, osec})
        c = 1'($urandom);
        lvl <= 1'b0;
        boot(1'b1, 1'b1, c);
        `CHK("forced", 1, fb)
        `CHK("exec_boot", 1, xb)
        `CHK("opt_keep", {1'b1, c}, {osel, osec})
        `CHK("force_rd", 1, frd)
        @(posedge clk);
        w = 0;
        repeat (8)
        begin
            p = lck;
            @(posedge clk);
            w += int'(lck !== p);
        end
        `CHK("load_clk", 4, w)
        prog.leave(3);
        repeat (6) @(posedge clk);
        #1;
        `CHK("load_oe", 0, loe)
        `CHK("force_rd", 0, frd)
        @(posedge clk);
        for (int s = 1; s >= 0; s--)
        begin
            boot(1'b0, 1'(s), 1'b1);
            `CHK("exec_boot", s == 0, xb)
            @(posedge clk);
        end
        apb(1'b1, OFS_TIMING, 32'h0000_0010);
        op(32'h0000_0004);
        `CHK("opt_mass", 2'b00, {osel, osec})
        print_verdict();
    end
endmodule
`default_nettype wire
